// ### pmic_host_model.sv
// Host processor model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module pmic_host_model (
    input wire logic clk, aw_rdy, w_rdy, b_vld, ar_rdy, r_vld,
    output logic [7:0] awa, ara,
    output logic [31:0] wd,
    output logic [3:0] ws,
    output logic aw_vld, w_vld, b_rdy, ar_vld, r_rdy
);
    initial {awa, ara, wd, ws, aw_vld, w_vld, b_rdy, ar_vld, r_rdy} = '0;
    // Ready for the answer from the start, so no response is stalled
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk);
        {awa, wd, ws} <= {a, dat, 4'hF};
        {aw_vld, w_vld, b_rdy} <= 3'h7;
        do begin
            @(posedge clk);
            if (aw_rdy) aw_vld <= 1'b0;
            if (w_rdy) w_vld <= 1'b0;
        end while (!(b_vld && b_rdy));
        {b_rdy, awa, wd} <= {1'b0, ~awa, ~wd};
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        {ara, ar_vld, r_rdy} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (ar_rdy) ar_vld <= 1'b0;
        end while (!(r_vld && r_rdy));
        {r_rdy, ara} <= {1'b0, ~ara};
    endtask
endmodule
`default_nettype wire

// ### pmic_regs_monitor.sv
// Assertion checker for the supervisor register bank
`timescale 1ns/1ps
`default_nettype none
module pmic_regs_monitor #(parameter int MS_CYCLES_P = 4) (
    input wire logic i_sys_clk, i_sys_rst, i_s_axi_arvalid,
    input wire logic o_s_axi_arready, o_s_axi_rvalid, o_reset_n,
    input wire logic o_bb_ramp_done, o_shipment_mode,
    input wire pmic_regs_pkg::bb_ctrl_t o_bb_ctrl,
    input wire logic [12:0] o_bb_target_mv,
    input wire logic [9:0] o_bb_peak_limit_ma, o_bb_switch_delay_cyc
);
    import pmic_regs_pkg::*;
    wire logic [5:0] v = o_bb_ctrl.bb_voltage_code;
    wire logic [1:0] d = o_bb_ctrl.bb_switch_delay_sel;
    int low;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // Reset output low time, in clocks
    always_ff @(posedge i_sys_clk) low <= (i_sys_rst | o_reset_n) ? 0 : low+1;
    // Skip the release edge: reset zeros fail the voltage and peak limit decodes
    sequence s_still;
        !$past(i_sys_rst) && $stable(o_bb_ctrl)
        && o_bb_ctrl == $past(o_bb_ctrl, 2);
    endsequence
    a_limit_code: assert property (s_still |->
        o_bb_peak_limit_ma == 10'(o_bb_ctrl.bb_peak_limit_sel) * 10'h064
        + 10'h064) else $error("peak limit mismatch");
    a_delay_code: assert property (s_still |->
        o_bb_switch_delay_cyc == ((d == 2'h3) ? 10'h320 : 10'(d) * 10'h0C8))
        else $error("switch delay mismatch");
    a_volt_code: assert property (s_still |-> o_bb_target_mv ==
        ((v < 6'h0C) ? 13'h0708 + 13'(v) * 13'h064
        : 13'h0B86 + 13'(v - 6'h0C) * 13'h032)) else $error("volt mismatch");
    a_ramp_enable: assert property ($rose(o_bb_ramp_done)
        |-> o_bb_ctrl.bb_output_en) else $error("ramp without enable");
    a_ramp_off: assert property (!o_bb_ctrl.bb_output_en [*2]
        |-> !o_bb_ramp_done) else $error("ramp with output off");
    a_reset_hold: assert property ($rose(o_reset_n)
        |-> low >= 199 * MS_CYCLES_P) else $error("reset pulse short");
    a_ship_latch: assert property (o_shipment_mode
        |=> o_shipment_mode) else $error("shipment mode dropped");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
        |=> o_s_axi_rvalid) else $error("read not answered");
    cover property ($rose(o_bb_ramp_done));
    cover property ($fell(o_reset_n));
    cover property (o_s_axi_rvalid);
endmodule
bind pmic_supervisor_fault_regs pmic_regs_monitor #(.MS_CYCLES_P(MS_CYCLES_P))
    pmic_regs_monitor_i (.i_sys_clk, .i_sys_rst, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rvalid, .o_reset_n, .o_bb_ramp_done,
    .o_shipment_mode, .o_bb_ctrl, .o_bb_target_mv, .o_bb_peak_limit_ma,
    .o_bb_switch_delay_cyc);
`default_nettype wire

// ### pmic_regs_pkg.sv
// Constants, field layout and carrier types of the supervisor register bank
package pmic_regs_pkg;

    // ********************
    // Register indices (byte address is four times the index)
    // ********************
    localparam int              ADDR_W      = 8;
    localparam logic [5:0]      IDX_BB_CFG  = 6'h2B;
    localparam logic [5:0]      IDX_BB_VOLT = 6'h2C;
    localparam logic [5:0]      IDX_SUPV    = 6'h2D;
    localparam logic [5:0]      IDX_FAULT   = 6'h2E;
    localparam logic [5:0]      IDX_STATUS  = 6'h2F;

    // ********************
    // Field positions
    // ********************
    localparam int SS_HI   = 7;
    localparam int SS_LO   = 6;
    localparam int ILIM_HI = 5;
    localparam int ILIM_LO = 3;
    localparam int STP_B   = 2;
    localparam int DIS_B   = 1;
    localparam int EN_B    = 0;
    localparam int DLY_HI  = 7;
    localparam int DLY_LO  = 6;
    localparam int VC_HI   = 5;
    localparam int VC_LO   = 0;
    localparam int MON1_B  = 7;
    localparam int MON2_B  = 6;
    localparam int RTIME_B = 5;
    localparam int WD_HI   = 4;
    localparam int WD_LO   = 3;
    localparam int WDEN_B  = 2;
    localparam int SHIP_B  = 1;
    localparam int KICK_B  = 0;
    localparam int UV_B    = 7;
    localparam int OC_B    = 6;
    localparam int COC_B   = 5;
    localparam int COV_B   = 4;
    localparam int WDT_B   = 2;
    localparam int TSD_B   = 0;
    localparam int BTN_B   = 5;
    localparam int CDONE_B = 4;
    localparam int VIN_B   = 3;
    localparam int WEAK_B  = 2;
    localparam int BBPG_B  = 1;
    localparam int SDPG_B  = 0;

    // ********************
    // Reset values
    // ********************
    localparam logic [7:0] BB_CFG_RST  = 8'h18;
    localparam logic [7:0] BB_VOLT_RST = 8'h00;
    localparam logic [7:0] SUPV_RST    = 8'h80;

    // ********************
    // Timing and scaling
    // ********************
    localparam int CLK_HZ       = 40_000_000;
    localparam int MS_CYCLES    = CLK_HZ / 1000;
    localparam int US_CYCLES    = CLK_HZ / 1_000_000;
    localparam int SS_MS0       = 1;
    localparam int SS_MS1       = 8;
    localparam int SS_MS2       = 64;
    localparam int SS_MS3       = 512;
    localparam int DLY_US1      = 5;
    localparam int DLY_US2      = 10;
    localparam int DLY_US3      = 20;
    localparam int RST_SHORT_MS = 200;
    localparam int RST_LONG_MS  = 1600;
    localparam int WD_MS0       = 12500;
    localparam int WD_MS1       = 25600;
    localparam int WD_MS2       = 50000;
    localparam int WD_MS3       = 100000;
    localparam int SHIP_MS      = 12000;
    localparam int DEGLITCH_MS  = 50;
    localparam int VC_BREAK     = 12;
    localparam int BASE1_MV     = 1800;
    localparam int STEP1_MV     = 100;
    localparam int BASE2_MV     = 2950;
    localparam int STEP2_MV     = 50;
    localparam int ILIM_STEP_MA = 100;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ********************
    // Carrier types
    // ********************
    typedef struct packed {
        logic charge_done_status;
        logic input_supply_good;
        logic cell_above_weak;
        logic bb_power_good;
        logic step_down_power_good;
    } status_in_t;

    typedef struct packed {
        logic cell_undervoltage;
        logic discharge_overcurrent;
        logic charge_overcurrent;
        logic charge_overvoltage;
        logic thermal_shutdown;
    } fault_evt_t;

    typedef struct packed {
        logic [1:0] bb_soft_start_sel;
        logic [2:0] bb_peak_limit_sel;
        logic       bb_pulse_stop_en;
        logic       bb_output_discharge_en;
        logic       bb_output_en;
        logic [1:0] bb_switch_delay_sel;
        logic [5:0] bb_voltage_code;
    } bb_ctrl_t;

    typedef enum logic [1:0] {
        RST_RUN  = 2'b00,
        RST_HOLD = 2'b01,
        RST_WAIT = 2'b11
    } rst_state_t;

endpackage

// ### pmic_supervisor_fault_regs.sv
// Supervisor, buck boost control and fault register bank on AXI4-Lite
// Function
// - Soft start code selects 1/8/64/512 ms
// - Peak limit code 100-800 mA, default 400
// - Pulse stop bit 2, off after reset
// - Output discharge bit 1 enables discharge
// - Enable bit 0 switches buck boost output
// - Switch delay code gives 0/5/10/20 us
// - Voltage code: 100 mV then 50 mV steps
// - Monitor bits 7 and 6 drive reset output
// - Reset timeout 200 ms or 1.6 s
// - Watchdog period 12.5/25.6/50/100 s
// - Watchdog runs only when enabled, off at reset
// - Button held 12 s enters shipment when enabled
// - Kick bit restarts watchdog, self clears
// - Four sticky battery fault flags, bits 7-4
// - Sticky watchdog and thermal flags, bits 2, 0
// - Write one or supply cycle clears flags
// - Status bit 5 shows button held
// - Status bit 4 shows charge complete
// - Status bit 3 shows input supply good
// - Status bit 2 live only with gauge enabled
// - Status bit 1 valid in fixed mode only
// - Status bit 0 void in load switch mode
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pmic_supervisor_fault_regs #(
    parameter int MS_CYCLES_P   = pmic_regs_pkg::MS_CYCLES,
    parameter int DEGLITCH_MS_P = pmic_regs_pkg::DEGLITCH_MS
) (
    input  wire logic                             i_sys_clk,
    input  wire logic                             i_sys_rst,
    input  wire logic [pmic_regs_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic                             i_s_axi_awvalid,
    output logic                                  o_s_axi_awready,
    input  wire logic [31:0]                      i_s_axi_wdata,
    input  wire logic [3:0]                       i_s_axi_wstrb,
    input  wire logic                             i_s_axi_wvalid,
    output logic                                  o_s_axi_wready,
    output logic [1:0]                            o_s_axi_bresp,
    output logic                                  o_s_axi_bvalid,
    input  wire logic                             i_s_axi_bready,
    input  wire logic [pmic_regs_pkg::ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic                             i_s_axi_arvalid,
    output logic                                  o_s_axi_arready,
    output logic [31:0]                           o_s_axi_rdata,
    output logic [1:0]                            o_s_axi_rresp,
    output logic                                  o_s_axi_rvalid,
    input  wire logic                             i_s_axi_rready,
    input  wire pmic_regs_pkg::status_in_t        i_status,
    input  wire pmic_regs_pkg::fault_evt_t        i_fault_evt,
    input  wire logic                             i_supply_power_cycle,
    input  wire logic                             i_manual_reset_button_n,
    input  wire logic                             i_fuel_gauge_en,
    input  wire logic                             i_bb_fixed_mode,
    input  wire logic                             i_buck_load_switch,
    output pmic_regs_pkg::bb_ctrl_t               o_bb_ctrl,
    output logic [12:0]                           o_bb_target_mv,
    output logic [9:0]                            o_bb_peak_limit_ma,
    output logic [9:0]                            o_bb_switch_delay_cyc,
    output logic                                  o_bb_ramp_done,
    output logic                                  o_reset_n,
    output logic                                  o_shipment_mode
);
    import pmic_regs_pkg::*;

    if (MS_CYCLES_P < 2 || DEGLITCH_MS_P < 1) begin : g_chk
        $error("Timing parameters out of range");
    end

    // ********************
    // Functions
    // ********************
    function automatic logic [5:0] reg_index(
        input logic [ADDR_W-1:0] addr
    );
        reg_index = addr[ADDR_W-1:2];
    endfunction

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx >= IDX_BB_CFG) && (idx <= IDX_STATUS);
    endfunction

    function automatic logic [12:0] code_to_mv(input logic [5:0] code);
        if (code < 6'(VC_BREAK)) begin
            code_to_mv = 13'(BASE1_MV + STEP1_MV * int'(code));
        end else begin
            code_to_mv = 13'(BASE2_MV
                + STEP2_MV * (int'(code) - VC_BREAK));
        end
    endfunction

    function automatic logic [16:0] wd_period_ms(input logic [1:0] sel);
        unique case (sel)
            2'h0: wd_period_ms = 17'(WD_MS0);
            2'h1: wd_period_ms = 17'(WD_MS1);
            2'h2: wd_period_ms = 17'(WD_MS2);
            2'h3: wd_period_ms = 17'(WD_MS3);
        endcase
    endfunction

    // ********************
    // Registers
    // ********************
    logic [7:0]          bb_cfg;
    logic [7:0]          bb_volt;
    logic [7:0]          supv;
    logic [7:0]          fault_flags;
    logic [7:0]          status;
    logic                aw_have;
    logic                w_have;
    logic [ADDR_W-1:0]   aw_addr;
    logic [7:0]          w_byte;
    logic                w_lane0;
    logic                wr_fire;
    logic [5:0]          wr_idx;
    logic                kick;
    logic                wd_expire;
    logic                button_held_status;
    logic [7:0]          next_fault;
    logic [7:0]          fault_set;

    assign o_s_axi_awready = !aw_have && !o_s_axi_bvalid;
    assign o_s_axi_wready  = !w_have && !o_s_axi_bvalid;
    assign o_s_axi_arready = !o_s_axi_rvalid;
    assign wr_fire = aw_have && w_have && !o_s_axi_bvalid;
    assign wr_idx  = reg_index(aw_addr);

    // ********************
    // AXI4-Lite write channel
    // ********************
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
        end else if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= i_s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            w_have  <= 1'b0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_have  <= 1'b1;
            w_byte  <= i_s_axi_wdata[7:0];
            w_lane0 <= i_s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // Control registers; a clear byte lane leaves the register alone
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            bb_cfg  <= BB_CFG_RST;
            bb_volt <= BB_VOLT_RST;
            supv    <= SUPV_RST;
        end else if (wr_fire && w_lane0) begin
            if (wr_idx == IDX_BB_CFG) begin
                bb_cfg <= w_byte;
            end
            if (wr_idx == IDX_BB_VOLT) begin
                bb_volt <= w_byte;
            end
            if (wr_idx == IDX_SUPV) begin
                supv <= w_byte;
                supv[KICK_B] <= 1'b0;
            end
        end
    end

    assign kick = wr_fire && w_lane0 && (wr_idx == IDX_SUPV)
        && w_byte[KICK_B];

    // ********************
    // Fault flags
    // ********************
    always_comb begin
        fault_set = 8'h00;
        fault_set[UV_B]  = i_fault_evt.cell_undervoltage;
        fault_set[OC_B]  = i_fault_evt.discharge_overcurrent;
        fault_set[COC_B] = i_fault_evt.charge_overcurrent;
        fault_set[COV_B] = i_fault_evt.charge_overvoltage;
        fault_set[WDT_B] = wd_expire;
        fault_set[TSD_B] = i_fault_evt.thermal_shutdown;
        next_fault = fault_flags;
        if (i_supply_power_cycle) begin
            next_fault = 8'h00;
        end else if (wr_fire && w_lane0 && wr_idx == IDX_FAULT) begin
            next_fault = fault_flags & ~w_byte;
        end
        // A new event in the clearing cycle must not be lost
        next_fault = next_fault | fault_set;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            fault_flags <= 8'h00;
        end else begin
            fault_flags <= next_fault;
        end
    end

    // ********************
    // Live status
    // ********************
    always_comb begin
        status = 8'h00;
        status[BTN_B]   = button_held_status;
        status[CDONE_B] = i_status.charge_done_status;
        status[VIN_B]   = i_status.input_supply_good;
        status[WEAK_B]  = i_status.cell_above_weak
            && i_fuel_gauge_en;
        status[BBPG_B]  = i_status.bb_power_good
            && i_bb_fixed_mode;
        status[SDPG_B]  = i_status.step_down_power_good
            && !i_buck_load_switch;
    end

    // ********************
    // AXI4-Lite read channel
    // ********************
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0000_0000;
            o_s_axi_rresp  <= RESP_OKAY;
        end else if (i_s_axi_arvalid && o_s_axi_arready) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rresp  <= RESP_OKAY;
            o_s_axi_rdata  <= 32'h0000_0000;
            unique case (reg_index(i_s_axi_araddr))
                IDX_BB_CFG:  o_s_axi_rdata[7:0] <= bb_cfg;
                IDX_BB_VOLT: o_s_axi_rdata[7:0] <= bb_volt;
                IDX_SUPV:    o_s_axi_rdata[7:0] <= supv;
                IDX_FAULT:   o_s_axi_rdata[7:0] <= fault_flags;
                IDX_STATUS:  o_s_axi_rdata[7:0] <= status;
                default:     o_s_axi_rresp      <= RESP_SLVERR;
            endcase
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    // ********************
    // Buck boost control outputs
    // ********************
    logic [9:0] ss_ms;
    logic [9:0] ss_cnt;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_bb_ctrl             <= '0;
            o_bb_target_mv        <= 13'h0000;
            o_bb_peak_limit_ma    <= 10'h000;
            o_bb_switch_delay_cyc <= 10'h000;
        end else begin
            o_bb_ctrl.bb_soft_start_sel      <= bb_cfg[SS_HI:SS_LO];
            o_bb_ctrl.bb_peak_limit_sel      <= bb_cfg[ILIM_HI:ILIM_LO];
            o_bb_ctrl.bb_pulse_stop_en       <= bb_cfg[STP_B];
            o_bb_ctrl.bb_output_discharge_en <= bb_cfg[DIS_B];
            o_bb_ctrl.bb_output_en           <= bb_cfg[EN_B];
            o_bb_ctrl.bb_switch_delay_sel    <= bb_volt[DLY_HI:DLY_LO];
            o_bb_ctrl.bb_voltage_code        <= bb_volt[VC_HI:VC_LO];
            o_bb_target_mv <= code_to_mv(bb_volt[VC_HI:VC_LO]);
            o_bb_peak_limit_ma <= 10'(ILIM_STEP_MA
                * (int'(bb_cfg[ILIM_HI:ILIM_LO]) + 1));
            unique case (bb_volt[DLY_HI:DLY_LO])
                2'h0: o_bb_switch_delay_cyc <= 10'h000;
                2'h1: o_bb_switch_delay_cyc <= 10'(DLY_US1 * US_CYCLES);
                2'h2: o_bb_switch_delay_cyc <= 10'(DLY_US2 * US_CYCLES);
                2'h3: o_bb_switch_delay_cyc <= 10'(DLY_US3 * US_CYCLES);
            endcase
        end
    end

    always_comb begin
        unique case (bb_cfg[SS_HI:SS_LO])
            2'h0: ss_ms = 10'(SS_MS0);
            2'h1: ss_ms = 10'(SS_MS1);
            2'h2: ss_ms = 10'(SS_MS2);
            2'h3: ss_ms = 10'(SS_MS3);
        endcase
    end

    // ********************
    // Millisecond tick
    // ********************
    // One shared tick keeps the long timers narrow; timing is
    // therefore accurate to one millisecond only
    logic [31:0] div_cnt;
    logic        ms_tick;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || ms_tick) begin
            div_cnt <= 32'h0000_0000;
        end else begin
            div_cnt <= div_cnt + 32'h0000_0001;
        end
    end

    assign ms_tick = (div_cnt == 32'(MS_CYCLES_P - 1));

    // Soft start ramp restarts whenever the output is disabled
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !bb_cfg[EN_B]) begin
            ss_cnt         <= 10'h000;
            o_bb_ramp_done <= 1'b0;
        end else if (ms_tick && !o_bb_ramp_done) begin
            ss_cnt <= ss_cnt + 10'h001;
            if (ss_cnt + 10'h001 >= ss_ms) begin
                o_bb_ramp_done <= 1'b1;
            end
        end
    end

    // ********************
    // Watchdog
    // ********************
    logic [16:0] wd_cnt;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !supv[WDEN_B] || kick) begin
            wd_cnt <= 17'h00000;
        end else if (ms_tick) begin
            if (wd_cnt + 17'h00001 >= wd_period_ms(supv[WD_HI:WD_LO])) begin
                wd_cnt <= 17'h00000;
            end else begin
                wd_cnt <= wd_cnt + 17'h00001;
            end
        end
    end

    assign wd_expire = supv[WDEN_B] && !kick && ms_tick
        && (wd_cnt + 17'h00001 >= wd_period_ms(supv[WD_HI:WD_LO]));

    // ********************
    // Manual reset button
    // ********************
    logic [13:0] btn_cnt;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_manual_reset_button_n) begin
            btn_cnt <= 14'h0000;
        end else if (ms_tick && btn_cnt != 14'(SHIP_MS)) begin
            btn_cnt <= btn_cnt + 14'h0001;
        end
    end

    assign button_held_status =
        (btn_cnt >= 14'(DEGLITCH_MS_P));

    // Shipment mode latches; only a system reset leaves it
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_shipment_mode <= 1'b0;
        end else if (supv[SHIP_B] && btn_cnt == 14'(SHIP_MS)) begin
            o_shipment_mode <= 1'b1;
        end
    end

    // ********************
    // Reset output
    // ********************
    rst_state_t  rst_state;
    logic [10:0] rst_cnt;
    logic        rst_cause;
    logic [10:0] rst_ms;

    assign rst_cause = (supv[MON1_B] && !status[SDPG_B])
        || (supv[MON2_B] && !status[BBPG_B]);
    assign rst_ms = supv[RTIME_B] ? 11'(RST_LONG_MS)
        : 11'(RST_SHORT_MS);

    // Power-on starts in the timeout so the system sees a full pulse
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rst_state <= RST_WAIT;
            rst_cnt   <= 11'h000;
        end else begin
            unique case (rst_state)
                RST_RUN: begin
                    rst_cnt <= 11'h000;
                    if (rst_cause || wd_expire) begin
                        rst_state <= RST_HOLD;
                    end
                end
                RST_HOLD: begin
                    rst_cnt <= 11'h000;
                    if (!rst_cause) begin
                        rst_state <= RST_WAIT;
                    end
                end
                RST_WAIT: begin
                    if (rst_cause) begin
                        rst_state <= RST_HOLD;
                    end else if (ms_tick) begin
                        if (rst_cnt + 11'h001 >= rst_ms) begin
                            rst_state <= RST_RUN;
                        end else begin
                            rst_cnt <= rst_cnt + 11'h001;
                        end
                    end
                end
                default: begin
                    rst_state <= RST_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_reset_n <= 1'b0;
        end else begin
            o_reset_n <= (rst_state == RST_RUN)
                && !rst_cause && !wd_expire;
        end
    end

endmodule
`default_nettype wire

// ### pmic_supervisor_fault_regs_bench.sv
// Self-checking bench for the supervisor register bank
`timescale 1ns/1ps
`default_nettype none
module pmic_supervisor_fault_regs_bench;
    import pmic_regs_pkg::*;
    logic clk = 0, rst = 1, pwr = 0, rn, aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
    logic aw_vld, w_vld, b_rdy, ar_vld, r_rdy, ship;
    logic [3:0] mode = 4'hD, ws;
    logic [7:0] awa, ara, c, vt[4] = '{8'h0B, 8'h4C, 8'h80, 8'hFF};
    logic [31:0] wd, rdat;
    logic [1:0] bres, rres, bq[$];
    logic [33:0] rq[$];
    status_in_t st = 5'h01;
    fault_evt_t ev = 5'h00;
    bb_ctrl_t ctl;
    int failures = 0, check_count = 0, seed = 32'h3681;
    always #12.5 clk = ~clk;
    pmic_supervisor_fault_regs #(.MS_CYCLES_P(4), .DEGLITCH_MS_P(2))
    pmic_supervisor_fault_regs_i (.i_sys_clk(clk), .i_sys_rst(rst),
        .i_s_axi_awaddr(awa), .i_s_axi_awvalid(aw_vld), .i_s_axi_wdata(wd),
        .o_s_axi_awready(aw_rdy), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(w_vld),
        .o_s_axi_wready(w_rdy), .o_s_axi_bresp(bres), .o_s_axi_bvalid(b_vld),
        .i_s_axi_bready(b_rdy), .i_s_axi_araddr(ara), .i_s_axi_rready(r_rdy),
        .i_s_axi_arvalid(ar_vld), .o_s_axi_arready(ar_rdy), .i_status(st),
        .o_s_axi_rdata(rdat), .o_s_axi_rresp(rres), .o_s_axi_rvalid(r_vld),
        .i_fault_evt(ev), .i_supply_power_cycle(pwr), .o_reset_n(rn),
        .i_manual_reset_button_n(mode[0]), .i_fuel_gauge_en(mode[3]),
        .i_bb_fixed_mode(mode[2]), .i_buck_load_switch(mode[1]), .o_bb_ctrl(ctl),
        .o_bb_target_mv(), .o_bb_peak_limit_ma(), .o_bb_switch_delay_cyc(),
        .o_bb_ramp_done(), .o_shipment_mode(ship));
    pmic_host_model pmic_host_model_i (.clk, .aw_rdy, .w_rdy, .b_vld, .ar_rdy,
        .r_vld, .awa, .ara, .wd, .ws, .aw_vld, .w_vld, .b_rdy, .ar_vld, .r_rdy);
    task automatic chk(string n, logic [33:0] e, logic [33:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] dat, logic [1:0] e);
        bq.push_back(e);
        pmic_host_model_i.wr(a, {24'h000000, dat});
    endtask
    task automatic rd(logic [7:0] a, logic [33:0] e);
        rq.push_back(e);
        pmic_host_model_i.rd(a);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (r_vld && r_rdy) chk("read", rq.pop_front(), {rres, rdat});
        if (b_vld && b_rdy) chk("bresp", 34'(bq.pop_front()), 34'(bres));
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(8'hAC, 34'h018);
        rd(8'hB0, 34'h000);
        rd(8'hB4, 34'h080);
        c = {2'h0, 6'($random(seed))} | 8'h01;
        wr(8'hAC, c, RESP_OKAY);
        rd(8'hAC, {26'h0, c});
        foreach (vt[i]) begin
            wr(8'hB0, vt[i], RESP_OKAY);
            rd(8'hB0, {26'h0, vt[i]});
            chk("ctrl", {18'h0, c, vt[i]}, {18'h0, ctl});
        end
        wr(8'hC0, 8'hFF, RESP_SLVERR);
        rd(8'hC0, {RESP_SLVERR, 32'h0});
        $display("test config done");
        st <= 5'($random(seed)) | 5'h01;
        repeat (2) @(posedge clk);
        rd(8'hBC, {29'h0, st});
        mode <= 4'h2;
        repeat (16) @(posedge clk);
        chk("reset", 34'h0, 34'(rn));
        rd(8'hBC, {26'h0, 3'h1, st[4:3], 3'h0});
        mode <= 4'hD;
        ev <= 5'h1F;
        @(posedge clk);
        ev <= 5'h00;
        rd(8'hB8, 34'h0F1);
        wr(8'hB8, 8'h81, RESP_OKAY);
        rd(8'hB8, 34'h070);
        pwr <= 1'b1;
        @(posedge clk);
        pwr <= 1'b0;
        rd(8'hB8, 34'h000);
        $display("test status and faults done");
        mode <= 4'hC;
        wr(8'hB4, 8'h86, RESP_OKAY);
        repeat (30000) @(posedge clk);
        chk("reset", 34'h1, 34'(rn));
        chk("ship", 34'h0, 34'(ship));
        wr(8'hB4, 8'h87, RESP_OKAY);
        rd(8'hB4, 34'h086);
        repeat (26000) @(posedge clk);
        rd(8'hB8, 34'h000);
        while (rn) @(posedge clk);
        chk("ship", 34'h1, 34'(ship));
        rd(8'hB8, 34'h004);
        $display("test watchdog done");
        complete_run;
    end
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        complete_run;
    end
endmodule
`default_nettype wire
